/* ulpi_link_interface.sv */
// Link end of a ULPI transceiver port: byte streams on clk, pins on ulpiClk.
// Assumes ulpiClk runs free while sys_rst is applied, from PHY or oscillator.
`timescale 1ns/10ps

// How it works
// R1 - Idle link owner drives all-zero data
// R2 - Transfer starts with a non-zero byte
// R3 - PHY raises DIR before driving data
// R4 - One discarded turnaround cycle per DIR change
// R5 - PHY idles DIR low, watching for data
// R6 - NXT from PHY paces every byte
// R7 - STP high marks end of sent stream
// R8 - STP high asks PHY for the bus
// R9 - All link pins timed on ulpiClk
// R10 - PHY-sourced clock: our clock pin is input
// R11 - External clock also enters as input
// R12 - DIR high: release data, capture bytes
module ulpi_link_interface
  import ulpi_link_pkg::*;
#(
  parameter int TX_DEPTH = TX_DEPTH_DEF,
  parameter int RX_DEPTH = RX_DEPTH_DEF
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Clock sourcing strap and its captured value
  input  wire logic       phySourcedClockSetting,
  output wire logic       clockFromPhy,
  // Transmit stream
  input  wire logic       txValid,
  output wire logic       txReady,
  input  wire tx_word_s   txWord,
  // Receive stream
  output wire logic       rxValid,
  input  wire logic       rxReady,
  output wire rx_word_s   rxWord,
  // Event pulses
  output wire logic       rxDropped,
  output wire logic       txAborted,
  // Transceiver link
  input  wire logic       ulpiClk,
  input  wire logic [7:0] ulpiDataIn,
  output wire logic [7:0] ulpiDataOut,
  output wire logic       ulpiDataOe,
  input  wire logic       ulpiDir,
  input  wire logic       ulpiNxt,
  output wire logic       ulpiStp
);

  localparam int LCW = $clog2(TX_DEPTH + 1);

  // System domain
  logic                   rstDly_r;
  logic                   clkMode_r;
  logic [SYNC_STAGES-1:0] strapSync_r;
  logic [EVENT_COUNT-1:0] evPulse_r;
  logic [EVENT_COUNT-1:0] evSeen_r;
  logic [SYNC_STAGES-1:0] evSync_r [EVENT_COUNT];
  logic [EVENT_COUNT-1:0] evNew;

  // Link domain
  logic [SYNC_STAGES-1:0] rstSync_r;
  logic                   linkRst_r;
  link_state_e            state_r;
  link_state_e            stateNxt;
  logic [7:0]             dataOut_r;
  logic [7:0]             dataOutNxt;
  logic                   dataOe_r;
  logic                   stp_r;
  logic                   stpNxt;
  logic [LCW-1:0]         lastCnt_r;
  logic [EVENT_COUNT-1:0] evTog_r;
  logic [EVENT_COUNT-1:0] evHit;

  // Crossing and buffer wiring
  logic                   txxValid;
  logic                   txxReady;
  tx_word_s               txxWord;
  logic                   txHeadValid;
  tx_word_s               txHead;
  logic                   txPeekValid;
  tx_word_s               txPeek;
  logic                   rxSrcReady;
  logic                   rxxValid;
  logic                   rxxReady;
  rx_word_s               rxxWord;
  rx_word_s               rxCapture;

  // Decodes
  wire logic              rstAgree;
  wire logic              strapAgree;
  wire logic              inIdle;
  wire logic              inTx;
  wire logic              inRx;
  wire logic              headZero;
  wire logic              packetReady;
  wire logic              txPop;
  wire logic              rxPush;
  wire logic              lastIn;
  wire logic              lastOut;
  wire logic              dataOeNxt;

  assign clockFromPhy = clkMode_r;
  assign rxDropped    = evPulse_r[EV_RX_DROP];
  assign txAborted    = evPulse_r[EV_TX_ABORT];
  assign ulpiDataOut  = dataOut_r;
  assign ulpiDataOe   = dataOe_r;
  assign ulpiStp      = stp_r;

  // Strap is a pin: a level still moving at release keeps the reset value
  assign strapAgree = strapSync_r[SYNC_STAGES-1] == strapSync_r[SYNC_STAGES-2];

  // R10 strap caught on release
  // R11 either source gives the same input clock
  always_ff @(posedge clk) begin
    rstDly_r    <= sys_rst;
    strapSync_r <= {strapSync_r[SYNC_STAGES-2:0], phySourcedClockSetting};
    if (sys_rst) begin
      clkMode_r <= CLK_MODE_RST;
    end else if (rstDly_r && strapAgree) begin
      clkMode_r <= strapSync_r[SYNC_STAGES-1];
    end
  end

  // Link reset follows sys_rst through the link synchroniser
  assign rstAgree = rstSync_r[SYNC_STAGES-1] == rstSync_r[SYNC_STAGES-2];

  always_ff @(posedge ulpiClk) begin
    rstSync_r <= {rstSync_r[SYNC_STAGES-2:0], sys_rst};
    if (rstAgree) begin
      linkRst_r <= rstSync_r[SYNC_STAGES-1];
    end
  end

  // Transmit words cross into the link domain, then wait in a staging FIFO
  word_cross #(
    .W($bits(tx_word_s))
  ) u_tx_cross (
    .srcClk   (clk),
    .srcRst   (sys_rst),
    .srcValid (txValid),
    .srcReady (txReady),
    .srcData  (txWord),
    .dstClk   (ulpiClk),
    .dstRst   (linkRst_r),
    .dstValid (txxValid),
    .dstReady (txxReady),
    .dstData  (txxWord)
  );

  shift_fifo #(
    .W     ($bits(tx_word_s)),
    .DEPTH (TX_DEPTH)
  ) u_tx_stage (
    .clk       (ulpiClk),
    .rst       (linkRst_r),
    .inValid   (txxValid),
    .inReady   (txxReady),
    .inData    (txxWord),
    .outValid  (txHeadValid),
    .outReady  (txPop),
    .outData   (txHead),
    .peekValid (txPeekValid),
    .peekData  (txPeek)
  );

  // Whole packet, or a full stage FIFO, staged first: the slow side cannot keep pace with NXT
  assign inIdle      = state_r == ST_IDLE;
  assign inTx        = state_r == ST_TX;
  assign inRx        = state_r == ST_RX;
  assign headZero    = txHead.data == IDLE_BYTE;
  assign packetReady = txHeadValid & ((lastCnt_r != '0) | ~txxReady);
  assign lastIn      = txxValid & txxReady & txxWord.last;
  assign lastOut     = txPop & txHead.last;
  // R2 zero head byte cannot open a transfer
  assign txPop       = (inIdle & ~ulpiDir & packetReady & headZero)
                     | (inTx & ~ulpiDir & ulpiNxt);

  // R12 bytes captured while the PHY owns the bus
  assign rxPush      = inRx & ulpiDir;
  assign rxCapture   = '{cmd: ~ulpiNxt, data: ulpiDataIn};
  assign evHit[EV_RX_DROP]  = rxPush & ~rxSrcReady;
  assign evHit[EV_TX_ABORT] = inTx & ulpiDir;

  always_comb begin
    stateNxt   = state_r;
    // R1 zero whenever nothing is being sent
    dataOutNxt = IDLE_BYTE;
    stpNxt     = STP_RST;
    case (state_r)
      ST_IDLE: begin
        // R3 DIR high means the PHY takes the bus
        // R5 otherwise the PHY sits listening
        if (ulpiDir) begin
          stateNxt = ST_TURN_IN;
        end else if (packetReady && !headZero) begin
          // R2 non-zero byte starts the transfer
          stateNxt   = ST_TX;
          dataOutNxt = txHead.data;
        end
      end
      ST_TX: begin
        if (ulpiDir) begin
          stateNxt = ST_TURN_IN;
        end else if (ulpiNxt) begin
          // R6 byte taken, next one or the end
          if (txHead.last || !txPeekValid) begin
            // R7 stop after the final byte
            stateNxt = ST_STOP;
            stpNxt   = 1'b1;
          end else begin
            dataOutNxt = txPeek.data;
          end
        end else begin
          dataOutNxt = dataOut_r;
        end
      end
      ST_STOP: begin
        stateNxt = ulpiDir ? ST_TURN_IN : ST_IDLE;
      end
      ST_TURN_IN: begin
        // R4 turnaround byte is discarded
        stateNxt = ulpiDir ? ST_RX : ST_TURN_OUT;
      end
      ST_RX: begin
        if (!ulpiDir) begin
          stateNxt = ST_TURN_OUT;
        end else if (!rxSrcReady) begin
          // R8 receiver stalled, ask for the bus back
          stpNxt = 1'b1;
        end
      end
      ST_TURN_OUT: begin
        // R4 one dead cycle before driving again
        stateNxt = ulpiDir ? ST_TURN_IN : ST_IDLE;
      end
      default: begin
        stateNxt = ST_IDLE;
      end
    endcase
  end

  // R12 drivers off while DIR is high or in turnaround
  assign dataOeNxt = ~ulpiDir
                   & ((stateNxt == ST_IDLE) | (stateNxt == ST_TX) | (stateNxt == ST_STOP));

  // R9 every pin launched and sampled on ulpiClk
  always_ff @(posedge ulpiClk) begin
    if (linkRst_r) begin
      state_r   <= ST_IDLE;
      dataOut_r <= IDLE_BYTE;
      dataOe_r  <= OE_RST;
      stp_r     <= STP_RST;
    end else begin
      state_r   <= stateNxt;
      dataOut_r <= dataOutNxt;
      dataOe_r  <= dataOeNxt;
      stp_r     <= stpNxt;
    end
  end

  always_ff @(posedge ulpiClk) begin
    if (linkRst_r) begin
      lastCnt_r <= '0;
      evTog_r   <= '0;
    end else begin
      lastCnt_r <= lastCnt_r + LCW'(lastIn) - LCW'(lastOut);
      evTog_r   <= evTog_r ^ evHit;
    end
  end

  // Received bytes cross back and queue for the user
  word_cross #(
    .W($bits(rx_word_s))
  ) u_rx_cross (
    .srcClk   (ulpiClk),
    .srcRst   (linkRst_r),
    .srcValid (rxPush),
    .srcReady (rxSrcReady),
    .srcData  (rxCapture),
    .dstClk   (clk),
    .dstRst   (sys_rst),
    .dstValid (rxxValid),
    .dstReady (rxxReady),
    .dstData  (rxxWord)
  );

  shift_fifo #(
    .W     ($bits(rx_word_s)),
    .DEPTH (RX_DEPTH)
  ) u_rx_buffer (
    .clk       (clk),
    .rst       (sys_rst),
    .inValid   (rxxValid),
    .inReady   (rxxReady),
    .inData    (rxxWord),
    .outValid  (rxValid),
    .outReady  (rxReady),
    .outData   (rxWord),
    .peekValid (),
    .peekData  ()
  );

  // Link events arrive as toggles; a change counts once stages agree
  for (genvar e = 0; e < EVENT_COUNT; e++) begin : g_event
    assign evNew[e] = (evSync_r[e][SYNC_STAGES-1] == evSync_r[e][SYNC_STAGES-2])
                    & (evSync_r[e][SYNC_STAGES-1] != evSeen_r[e]);

    always_ff @(posedge clk) begin
      evSync_r[e] <= {evSync_r[e][SYNC_STAGES-2:0], evTog_r[e]};
      if (sys_rst) begin
        evSeen_r[e]  <= 1'b0;
        evPulse_r[e] <= 1'b0;
      end else begin
        evSeen_r[e]  <= evNew[e] ? evSync_r[e][SYNC_STAGES-1] : evSeen_r[e];
        evPulse_r[e] <= evNew[e];
      end
    end
  end

endmodule : ulpi_link_interface

/* ulpi_link_pkg.sv */
// Shared constants and types of the ULPI link block.
// Assumes a SystemVerilog-2012 tool chain; nothing else.
package ulpi_link_pkg;

  localparam logic [7:0] IDLE_BYTE    = 8'h00;
  localparam logic       STP_RST      = 1'b0;
  localparam logic       OE_RST       = 1'b0;
  localparam logic       CLK_MODE_RST = 1'b1;
  localparam int         SYNC_STAGES  = 3;
  localparam int         TX_DEPTH_DEF = 4;
  localparam int         RX_DEPTH_DEF = 2;
  localparam int         EVENT_COUNT  = 2;
  localparam int         EV_RX_DROP   = 0;
  localparam int         EV_TX_ABORT  = 1;

  // Gray along idle -> turn in -> receive -> turn out -> idle
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_TX       = 3'h1,
    ST_STOP     = 3'h3,
    ST_TURN_IN  = 3'h2,
    ST_RX       = 3'h6,
    ST_TURN_OUT = 3'h4
  } link_state_e;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } tx_word_s;

  typedef struct packed {
    logic       cmd;
    logic [7:0] data;
  } rx_word_s;

endpackage : ulpi_link_pkg

/* shift_fifo.sv */
// Small shift-register FIFO; head entry and the one behind it are flops.
// Assumes one clock, synchronous active-high reset, DEPTH of 2 or more.
`timescale 1ns/10ps
module shift_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         inValid,
  output wire logic         inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output wire logic         outValid,
  input  wire logic         outReady,
  output wire logic [W-1:0] outData,
  // Entry behind the head
  output wire logic         peekValid,
  output wire logic [W-1:0] peekData
);

  logic [W-1:0]     mem_r [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] shVld;
  logic [W-1:0]     shData [DEPTH];
  logic [DEPTH-1:0] lowerFull;
  logic [DEPTH-1:0] wr;
  wire logic        pop;
  wire logic        push;

  // No pass-through on full: keeps inReady a pure flop term
  assign inReady   = ~vld_r[DEPTH-1];
  assign pop       = vld_r[0] & outReady;
  assign push      = inValid & inReady;
  assign outValid  = vld_r[0];
  assign outData   = mem_r[0];
  assign peekValid = vld_r[1];
  assign peekData  = mem_r[1];
  assign lowerFull = {shVld[DEPTH-2:0], 1'b1};

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    if (i == DEPTH - 1) begin : g_top
      assign shVld[i]  = pop ? 1'b0 : vld_r[i];
      assign shData[i] = mem_r[i];
    end else begin : g_mid
      assign shVld[i]  = pop ? vld_r[i+1] : vld_r[i];
      assign shData[i] = pop ? mem_r[i+1] : mem_r[i];
    end
    assign wr[i] = push & ~shVld[i] & lowerFull[i];

    always_ff @(posedge clk) begin
      if (rst) begin
        vld_r[i] <= 1'b0;
      end else begin
        vld_r[i] <= shVld[i] | wr[i];
      end
      mem_r[i] <= wr[i] ? inData : shData[i];
    end
  end

endmodule : shift_fifo

/* word_cross.sv */
// Word crossing between two unrelated clocks by toggle handshake.
// Assumes each side has its own synchronous active-high reset.
`timescale 1ns/10ps
module word_cross
  import ulpi_link_pkg::*;
#(
  parameter int W = 8
) (
  // Source domain
  input  wire logic         srcClk,
  input  wire logic         srcRst,
  input  wire logic         srcValid,
  output wire logic         srcReady,
  input  wire logic [W-1:0] srcData,
  // Destination domain
  input  wire logic         dstClk,
  input  wire logic         dstRst,
  output wire logic         dstValid,
  input  wire logic         dstReady,
  output wire logic [W-1:0] dstData
);

  logic                   reqTog_r;
  logic                   srcReady_r;
  logic [W-1:0]           hold_r;
  logic [SYNC_STAGES-1:0] ackSync_r;
  logic                   ackTog_r;
  logic                   dstValid_r;
  logic [W-1:0]           dstData_r;
  logic [SYNC_STAGES-1:0] reqSync_r;
  wire logic              fire;
  wire logic              ackBack;
  wire logic              newReq;
  wire logic              take;

  assign fire     = srcValid & srcReady_r;
  assign ackBack  = (ackSync_r[SYNC_STAGES-1] == ackSync_r[SYNC_STAGES-2])
                  & (ackSync_r[SYNC_STAGES-1] == reqTog_r);
  assign newReq   = (reqSync_r[SYNC_STAGES-1] == reqSync_r[SYNC_STAGES-2])
                  & (reqSync_r[SYNC_STAGES-1] != ackTog_r) & ~dstValid_r;
  assign take     = dstValid_r & dstReady;
  assign srcReady = srcReady_r;
  assign dstValid = dstValid_r;
  assign dstData  = dstData_r;

  always_ff @(posedge srcClk) begin
    ackSync_r <= {ackSync_r[SYNC_STAGES-2:0], ackTog_r};
    if (srcRst) begin
      reqTog_r   <= 1'b0;
      srcReady_r <= 1'b1;
    end else begin
      reqTog_r   <= reqTog_r ^ fire;
      srcReady_r <= fire ? 1'b0 : (ackBack | srcReady_r);
    end
    if (fire) begin
      hold_r <= srcData;
    end
  end

  // Held word is stable from the toggle until the ack returns
  always_ff @(posedge dstClk) begin
    reqSync_r <= {reqSync_r[SYNC_STAGES-2:0], reqTog_r};
    if (dstRst) begin
      ackTog_r   <= 1'b0;
      dstValid_r <= 1'b0;
    end else begin
      ackTog_r   <= ackTog_r ^ take;
      dstValid_r <= newReq | (dstValid_r & ~take);
    end
    if (newReq) begin
      dstData_r <= hold_r;
    end
  end

endmodule : word_cross

/* ulpi_link_interface_sva.sv */
// Checker of the link pins and the transmit handshake.
// Bound into ulpi_link_interface; sees only its ports.
`timescale 1ns/10ps
module ulpi_link_interface_sva
  import ulpi_link_pkg::*;
(
  // Clocks and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ulpiClk,
  // Stream side
  input wire logic       clockFromPhy,
  input wire logic       txValid,
  input wire logic       txReady,
  // Link pins
  input wire logic [7:0] ulpiDataOut,
  input wire logic       ulpiDataOe,
  input wire logic       ulpiDir,
  input wire logic       ulpiNxt,
  input wire logic       ulpiStp
);
  dir_owns_bus_a: assert property (@(posedge ulpiClk) disable iff (sys_rst)
    ulpiDir |=> !ulpiDataOe) else $error("data driven while DIR high");
  turn_out_a: assert property (@(posedge ulpiClk) disable iff (sys_rst)
    $fell(ulpiDir) ##1 !ulpiDir |-> !ulpiDataOe ##1 (ulpiDataOe && ulpiDataOut == IDLE_BYTE))
    else $error("turnaround after DIR fall wrong");
  oe_rise_idle_a: assert property (@(posedge ulpiClk) disable iff (sys_rst)
    $rose(ulpiDataOe) |-> ulpiDataOut == IDLE_BYTE) else $error("bus taken with non-zero data");
  stp_single_a: assert property (@(posedge ulpiClk) disable iff (sys_rst)
    ulpiStp && ulpiDataOe && $past(ulpiDataOe) && $past(ulpiDataOut) != IDLE_BYTE
    |-> ulpiDataOut == IDLE_BYTE ##1 !ulpiStp) else $error("stop pulse malformed");
  hold_data_a: assert property (@(posedge ulpiClk) disable iff (sys_rst)
    ulpiDataOe && !ulpiDir && !ulpiNxt && !ulpiStp && ulpiDataOut != IDLE_BYTE
    |=> $stable(ulpiDataOut) || !ulpiDataOe) else $error("data moved without NXT");
  byte_advance_a: assert property (@(posedge ulpiClk) disable iff (sys_rst)
    ulpiDataOe && !ulpiDir && ulpiNxt && ulpiDataOut != IDLE_BYTE
    |=> ulpiDataOut != $past(ulpiDataOut) || ulpiStp || !ulpiDataOe)
    else $error("accepted byte not advanced");
  tx_take_a: assert property (@(posedge clk) disable iff (sys_rst)
    txValid && txReady |=> !txReady) else $error("ready held after take");
  strap_reset_a: assert property (@(posedge clk)
    sys_rst |=> clockFromPhy) else $error("clock strap not at reset value");
endmodule : ulpi_link_interface_sva

bind ulpi_link_interface ulpi_link_interface_sva u_ulpi_link_interface_sva (
  .clk(clk), .sys_rst(sys_rst), .ulpiClk(ulpiClk), .clockFromPhy(clockFromPhy),
  .txValid(txValid), .txReady(txReady), .ulpiDataOut(ulpiDataOut),
  .ulpiDataOe(ulpiDataOe), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiStp(ulpiStp));

/* ulpi_phy_model.sv */
// Behavioural transceiver at the far end of the link pins.
// Assumes a free-running ulpiClk; the bench calls frame() to send.
`timescale 1ns/10ps
module ulpi_phy_model (
  // Link clock
  input  wire logic       ulpiClk,
  // Pins from the link
  input  wire logic [7:0] linkData,
  input  wire logic       linkOe,
  input  wire logic       ulpiStp,
  // Pins toward the link
  output var  logic       ulpiDir,
  output var  logic       ulpiNxt,
  output wire logic [7:0] busLevel,
  // Pacing knobs
  input  wire logic       nxtSlow,
  input  wire logic       nxtHold
);
  logic [7:0] phyData = 8'h00;
  logic       phyOe = 1'b0;
  logic [7:0] lastBus = 8'h00;
  logic [7:0] gotQ[$];
  int         pktCount = 0;
  int         stpInRx = 0;
  initial ulpiDir = 1'b0;
  initial ulpiNxt = 1'b0;
  // Undriven bus shows the inverse of its last level
  assign busLevel = linkOe ? linkData : (phyOe ? phyData : ~lastBus);
  always @(posedge ulpiClk) begin
    if (linkOe || phyOe) lastBus <= busLevel;
  end
  // Idle listener, NXT paces each byte
  always @(posedge ulpiClk) begin
    if (!ulpiDir) begin
      if (ulpiNxt && linkOe && linkData != 8'h00 && !ulpiStp) gotQ.push_back(linkData);
      if (ulpiStp && linkOe) pktCount++;
      ulpiNxt <= linkOe && linkData != 8'h00 && !ulpiStp && !nxtHold && !(nxtSlow && ulpiNxt);
    end else if (ulpiStp) begin
      stpInRx++;
    end
  end
  task automatic frame(input logic [7:0] b, input int n, input logic isData);
    @(posedge ulpiClk) ulpiDir <= 1'b1;
    @(posedge ulpiClk);
    for (int i = 0; i < n; i++) begin
      @(posedge ulpiClk) begin
        phyOe <= 1'b1;
        phyData <= b + i[7:0];
        ulpiNxt <= isData;
      end
    end
    @(posedge ulpiClk) begin
      ulpiDir <= 1'b0;
      phyOe <= 1'b0;
      ulpiNxt <= 1'b0;
    end
  endtask : frame
endmodule : ulpi_phy_model

/* ulpi_link_interface_bench.sv */
// Self-checking bench of the ULPI link block with a behavioural PHY.
// Assumes package, design and model files are compiled ahead of it.
`timescale 1ns/10ps
module ulpi_link_interface_bench
  import ulpi_link_pkg::*;
  ;
  logic       clk = 0, sys_rst = 1, ulpiClk = 0, strap = 0;
  logic       txValid = 0, rxReady = 0, nxtSlow = 0, nxtHold = 0;
  tx_word_s   txWord = '0;
  rx_word_s   rxWord;
  logic       txReady, rxValid, rxDropped, txAborted, clockFromPhy;
  logic       ulpiDataOe, ulpiStp, ulpiDir, ulpiNxt;
  logic [7:0] ulpiDataOut, busLevel;
  int         bad_count = 0, checks = 0, drops = 0, aborts = 0;

  always #50 clk = ~clk;
  always #32 ulpiClk = ~ulpiClk;
  always @(posedge clk) begin
    if (rxDropped === 1'b1) drops++;
    if (txAborted === 1'b1) aborts++;
  end

  ulpi_link_interface u_ulpi_link_interface (.clk(clk), .sys_rst(sys_rst),
    .phySourcedClockSetting(strap), .clockFromPhy(clockFromPhy), .txValid(txValid),
    .txReady(txReady), .txWord(txWord), .rxValid(rxValid), .rxReady(rxReady),
    .rxWord(rxWord), .rxDropped(rxDropped), .txAborted(txAborted), .ulpiClk(ulpiClk),
    .ulpiDataIn(busLevel), .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe),
    .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiStp(ulpiStp));
  ulpi_phy_model u_phy (.ulpiClk(ulpiClk), .linkData(ulpiDataOut), .linkOe(ulpiDataOe),
    .ulpiStp(ulpiStp), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .busLevel(busLevel),
    .nxtSlow(nxtSlow), .nxtHold(nxtHold));

  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic timeout;
    bad_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    end_sim();
  endtask : timeout
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic push(input tx_word_s w);
    int n = 0;
    @(negedge clk);
    txValid = 1'b1;
    txWord = w;
    while (txReady !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) timeout();
    end
    @(negedge clk);
    txValid = 1'b0;
  endtask : push
  task automatic pop(input rx_word_s exp);
    int n = 0;
    @(negedge clk);
    while (rxValid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) timeout();
    end
    check(16'(rxWord), 16'(exp));
    rxReady = 1'b1;
    @(negedge clk);
    rxReady = 1'b0;
  endtask : pop
  task automatic wait_pkt(input int want);
    int n = 0;
    while (u_phy.pktCount < want) begin
      @(negedge clk);
      n++;
      if (n > 500) timeout();
    end
  endtask : wait_pkt

  task automatic test_reset(input logic s);
    strap = s;
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    check(16'(clockFromPhy), 16'h1);
    sys_rst = 1'b0;
    repeat (20) @(negedge clk);
    check(16'(clockFromPhy), 16'(s));
    check(16'(ulpiDataOe), 16'h1);
    check(16'(ulpiDataOut), 16'h0);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_tx;
    logic [7:0] expB[3] = '{8'h5a, 8'h3c, 8'h81};
    nxtSlow <= 1'b1;
    push('{1'b0, 8'h00});
    for (int i = 0; i < 3; i++) push('{i == 2, expB[i]});
    wait_pkt(1);
    check(16'(u_phy.pktCount), 16'h1);
    check(16'(u_phy.gotQ.size()), 16'h3);
    for (int i = 0; i < 3; i++) check(16'(u_phy.gotQ[i]), 16'(expB[i]));
    u_phy.gotQ.delete();
    $display("test_tx done");
  endtask : test_tx
  task automatic test_rx;
    u_phy.frame(8'ha5, 1, 1'b0);
    pop('{1'b1, 8'ha5});
    u_phy.frame(8'h17, 1, 1'b1);
    pop('{1'b0, 8'h17});
    $display("test_rx done");
  endtask : test_rx
  task automatic test_stall;
    u_phy.frame(8'h40, 6, 1'b1);
    repeat (10) @(negedge clk);
    check(16'(drops > 0), 16'h1);
    check(16'(u_phy.stpInRx > 0), 16'h1);
    pop('{1'b0, 8'h40});
    @(negedge clk);
    rxReady = 1'b1;
    repeat (40) @(negedge clk);
    rxReady = 1'b0;
    $display("test_stall done");
  endtask : test_stall
  task automatic test_abort;
    int n = 0;
    nxtHold <= 1'b1;
    nxtSlow <= 1'b0;
    push('{1'b1, 8'h2b});
    while (ulpiDataOut !== 8'h2b) begin
      @(negedge ulpiClk);
      n++;
      if (n > 300) timeout();
    end
    u_phy.frame(8'h66, 1, 1'b1);
    nxtHold <= 1'b0;
    wait_pkt(2);
    // Abort pulse needs a few clk edges to cross back
    repeat (5) @(negedge clk);
    check(16'(aborts), 16'h1);
    check(16'(u_phy.gotQ.size()), 16'h1);
    check(16'(u_phy.gotQ[0]), 16'h2b);
    pop('{1'b0, 8'h66});
    $display("test_abort done");
  endtask : test_abort
  // Mid-run reset with the other strap level, then one packet again
  task automatic test_rerun;
    test_reset(1'b1);
    push('{1'b1, 8'h5a});
    wait_pkt(3);
    check(16'(u_phy.gotQ[1]), 16'h5a);
    $display("test_rerun done");
  endtask : test_rerun

  initial begin
    test_reset(1'b0);
    test_tx();
    test_rx();
    test_stall();
    test_abort();
    test_rerun();
    end_sim();
  end
endmodule : ulpi_link_interface_bench
